// ---- logic/fncs_pkg.sv ----
// Constants, register map and divider arithmetic for the NCO clock synthesiser.
// Assumes one crystal-rate clock and a synchronous active-high reset.
// Summary of operation
// - Prescaler takes 5-bit divisor, 3-bit length, 8-bit pattern.
// - Pattern bit 0 divides by base, 1 by base+1.
// - Pattern length is length field plus one; upper bits ignored.
// - Zero length field gives plain base divide.
// - Integer ratio gives jitter-free plain divider output.
// - Host keeps reference between 2 and 4 MHz.
// - Host keeps pattern lengths at most 8.
// - Feedback divider: 7-bit divisor, same pattern rules.
// - VCO runs at 2 x 2304 x sample rate.
// - Charge-pump boost held until lock or force bit.
// - PLL settles within one frame-sync period.
// - Host writes 08h to 0Dh ascending, 0Dh last.
// - Write to 0Eh requests switch to PLL clock.
// - Reset runs system clock at crystal divided by 9.
// - No switch before second frame sync after 0Dh.
// - Switch passes through a glitch-free multiplexer.
package fncs_pkg;

	// --------------------------------------------------------------
	// Register map
	// --------------------------------------------------------------
	localparam logic [7:0] ADDR_PRE_BASE = 8'h08;
	localparam logic [7:0] ADDR_PRE_LEN  = 8'h09;
	localparam logic [7:0] ADDR_PRE_SEQ  = 8'h0A;
	localparam logic [7:0] ADDR_FB_BASE  = 8'h0B;
	localparam logic [7:0] ADDR_FB_LEN   = 8'h0C;
	localparam logic [7:0] ADDR_FB_SEQ   = 8'h0D;
	localparam logic [7:0] ADDR_SWITCH   = 8'h0E;

	localparam int PRE_BASE_W  = 5;
	localparam int FB_BASE_W   = 7;
	localparam int LEN_W       = 3;
	localparam int SEQ_W       = 8;
	localparam int FORCE_BIT   = 7;
	localparam int SWITCH_BIT  = 0;

	localparam logic [7:0] REG_RESET     = 8'h00;
	localparam logic [7:0] SWITCH_WORD   = 8'h01;

	// --------------------------------------------------------------
	// Timing counts
	// --------------------------------------------------------------
	localparam logic [3:0] XTAL_DIV      = 4'h9;
	localparam logic [1:0] FS_WAIT       = 2'h2;
	localparam int         VCO_PER_FS    = 2 * 2304;

	// Divisor for the current output period of either divider.
	function automatic logic [7:0] fncs_period(
		input logic [6:0] base,
		input logic [2:0] len,
		input logic [7:0] seq,
		input logic [2:0] pos
	);
		logic [7:0] d;
		d = {1'b0, base};
		if (len != 3'h0 && seq[pos]) begin
			d = d + 8'h01;
		end
		if (d == 8'h00) begin
			d = 8'h01;
		end
		return d;
	endfunction

	// Next pattern position, wrapping after the last entry.
	function automatic logic [2:0] fncs_next_pos(
		input logic [2:0] len,
		input logic [2:0] pos
	);
		return (pos >= len) ? 3'h0 : pos + 3'h1;
	endfunction

endpackage

// ---- logic/fncs_if.sv ----
// Register write port between the host and the clock synthesiser.
// Assumes both ends share mclk; the bench ties the clock and reset.
`timescale 1ns/1ps
interface fncs_if (
	input wire logic mclk,
	input wire logic rst
);
	logic       wr_stb;
	logic [7:0] addr;
	logic [7:0] wdata;
	logic [7:0] rdata;

	modport dev (
		input  mclk,
		input  rst,
		input  wr_stb,
		input  addr,
		input  wdata,
		output rdata
	);

	modport host (
		input  mclk,
		input  rst,
		output wr_stb,
		output addr,
		output wdata,
		input  rdata
	);
endinterface

// ---- logic/fncs_device.sv ----
// Clock synthesiser: prescaler NCO, feedback NCO, boost hold and clock switch.
// Assumes mclk is the crystal clock and vco_tick is a one-cycle pulse per
// VCO edge, synchronous to mclk, produced by the analog model outside.
`timescale 1ns/1ps
module fncs_device (
	fncs_if.dev        bus,
	input  wire logic  vco_tick,
	input  wire logic  pll_locked,
	input  wire logic  frame_sync,
	output logic       ref_tick,
	output logic       fb_tick,
	output logic       cp_boost,
	output logic       sys_tick,
	output logic       sys_on_pll
);
	import fncs_pkg::*;

	// --------------------------------------------------------------
	// State
	// --------------------------------------------------------------
	// Host-written fields are kept apart from the active copy (a_ fields)
	// that the dividers run on; the active copy changes only on a commit.
	typedef struct packed {
		logic [4:0] pre_base;
		logic [2:0] pre_len;
		logic [7:0] pre_seq;
		logic [6:0] fb_base;
		logic [2:0] fb_len;
		logic       force_vco;
		logic [7:0] fb_seq;
		logic       sw_req;
		logic [4:0] a_pre_base;
		logic [2:0] a_pre_len;
		logic [7:0] a_pre_seq;
		logic [6:0] a_fb_base;
		logic [2:0] a_fb_len;
		logic [7:0] a_fb_seq;
		logic [7:0] p_cnt;
		logic [2:0] p_pos;
		logic       p_tick;
		logic [7:0] n_cnt;
		logic [2:0] n_pos;
		logic       n_tick;
		logic [1:0] fs_cnt;
		logic       lock_seen;
		logic [3:0] x9_cnt;
		logic       x9_tick;
		logic       sel_pll;
		logic       sys_tick;
		logic [7:0] rdata;
	} fncs_dev_s;

	fncs_dev_s s_q;
	fncs_dev_s s_d;

	logic       wr;
	logic [7:0] p_div;
	logic [7:0] n_div;
	logic       commit;

	assign wr    = bus.wr_stb;
	// The closing divider write commits the whole set in one cycle.
	assign commit = wr && (bus.addr == ADDR_FB_SEQ);
	assign p_div = fncs_period({2'b00, s_q.a_pre_base}, s_q.a_pre_len,
		s_q.a_pre_seq, s_q.p_pos);
	assign n_div = fncs_period(s_q.a_fb_base, s_q.a_fb_len,
		s_q.a_fb_seq, s_q.n_pos);

	always_comb begin
		s_d          = s_q;
		s_d.p_tick   = 1'b0;
		s_d.n_tick   = 1'b0;
		s_d.x9_tick  = 1'b0;
		s_d.sys_tick = 1'b0;

		// ----------------------------------------------------------
		// Register writes
		// ----------------------------------------------------------
		if (wr) begin
			unique case (bus.addr)
				ADDR_PRE_BASE: s_d.pre_base = bus.wdata[PRE_BASE_W-1:0];
				ADDR_PRE_LEN:  s_d.pre_len  = bus.wdata[LEN_W-1:0];
				ADDR_PRE_SEQ:  s_d.pre_seq  = bus.wdata;
				ADDR_FB_BASE:  s_d.fb_base  = bus.wdata[FB_BASE_W-1:0];
				ADDR_FB_LEN: begin
					s_d.fb_len    = bus.wdata[LEN_W-1:0];
					s_d.force_vco = bus.wdata[FORCE_BIT];
				end
				ADDR_FB_SEQ:   s_d.fb_seq   = bus.wdata;
				ADDR_SWITCH:   s_d.sw_req   = 1'b1;
				default: ;
			endcase
		end

		// A complete set takes effect only on the closing write, so a
		// half-written set never reaches the dividers.
		if (commit) begin
			s_d.a_pre_base = s_q.pre_base;
			s_d.a_pre_len  = s_q.pre_len;
			s_d.a_pre_seq  = s_q.pre_seq;
			s_d.a_fb_base  = s_q.fb_base;
			s_d.a_fb_len   = s_q.fb_len;
			s_d.a_fb_seq   = bus.wdata;
			s_d.p_cnt      = 8'h00;
			s_d.p_pos      = 3'h0;
			s_d.n_cnt      = 8'h00;
			s_d.n_pos      = 3'h0;
			s_d.fs_cnt     = 2'h0;
		end else begin
			// ------------------------------------------------------
			// Prescaler on the crystal clock
			// ------------------------------------------------------
			if (s_q.p_cnt + 8'h01 >= p_div) begin
				s_d.p_cnt  = 8'h00;
				s_d.p_tick = 1'b1;
				s_d.p_pos  = fncs_next_pos(s_q.a_pre_len, s_q.p_pos);
			end else begin
				s_d.p_cnt = s_q.p_cnt + 8'h01;
			end

			// ------------------------------------------------------
			// Feedback divider on VCO edges
			// ------------------------------------------------------
			// At most one VCO edge is counted per crystal cycle, so a faster
			// loop clock must be brought in already divided down.
			if (vco_tick) begin
				if (s_q.n_cnt + 8'h01 >= n_div) begin
					s_d.n_cnt  = 8'h00;
					s_d.n_tick = 1'b1;
					s_d.n_pos  = fncs_next_pos(s_q.a_fb_len, s_q.n_pos);
				end else begin
					s_d.n_cnt = s_q.n_cnt + 8'h01;
				end
			end

			if (frame_sync && s_q.fs_cnt != FS_WAIT) begin
				s_d.fs_cnt = s_q.fs_cnt + 2'h1;
			end
		end

		// ----------------------------------------------------------
		// Charge-pump boost hold
		// ----------------------------------------------------------
		// A new closing write re-arms the boost so the loop relocks fast;
		// a lock or force in that same cycle still wins.
		if (commit) begin
			s_d.lock_seen = 1'b0;
		end
		if (pll_locked || s_q.force_vco) begin
			s_d.lock_seen = 1'b1;
		end

		// ----------------------------------------------------------
		// System clock source
		// ----------------------------------------------------------
		if (s_q.x9_cnt + 4'h1 >= XTAL_DIV) begin
			s_d.x9_cnt  = 4'h0;
			s_d.x9_tick = 1'b1;
		end else begin
			s_d.x9_cnt = s_q.x9_cnt + 4'h1;
		end

		// The select moves only on a crystal/9 period boundary, so the
		// last slow period is whole and no runt enable is emitted.
		// A commit in this cycle restarts the frame count, so it also holds
		// the switch off until two fresh frame syncs have been seen.
		if (!s_q.sel_pll && s_q.sw_req && s_q.fs_cnt == FS_WAIT
			&& s_d.x9_tick && !commit) begin
			s_d.sel_pll = 1'b1;
		end
		if (s_q.sel_pll) begin
			s_d.sys_tick = vco_tick;
		end else begin
			s_d.sys_tick = s_d.x9_tick;
		end

		// ----------------------------------------------------------
		// Readback
		// ----------------------------------------------------------
		// Data follows the address one cycle later; unmapped addresses read zero.
		unique case (bus.addr)
			ADDR_PRE_BASE: s_d.rdata = {3'h0, s_q.pre_base};
			ADDR_PRE_LEN:  s_d.rdata = {5'h00, s_q.pre_len};
			ADDR_PRE_SEQ:  s_d.rdata = s_q.pre_seq;
			ADDR_FB_BASE:  s_d.rdata = {1'b0, s_q.fb_base};
			ADDR_FB_LEN:   s_d.rdata = {s_q.force_vco, 4'h0, s_q.fb_len};
			ADDR_FB_SEQ:   s_d.rdata = s_q.fb_seq;
			ADDR_SWITCH:   s_d.rdata = {5'h00, s_q.lock_seen, s_q.sel_pll, s_q.sw_req};
			default:       s_d.rdata = 8'h00;
		endcase

		if (bus.rst) begin
			s_d = '0;
		end
	end

	always_ff @(posedge bus.mclk) begin
		s_q <= s_d;
	end

	// --------------------------------------------------------------
	// Outputs
	// --------------------------------------------------------------
	assign bus.rdata  = s_q.rdata;
	assign ref_tick   = s_q.p_tick;
	assign fb_tick    = s_q.n_tick;
	assign cp_boost   = !s_q.lock_seen;
	assign sys_tick   = s_q.sys_tick;
	assign sys_on_pll = s_q.sel_pll;

endmodule

// ---- logic/fncs_host.sv ----
// Host end: writes one sample-rate setting set, then requests the switch.
// Assumes the device accepts one write per mclk cycle with no wait.
`timescale 1ns/1ps
module fncs_host (
	fncs_if.host            bus,
	input  wire logic       start,
	input  wire logic [4:0] pre_base,
	input  wire logic [2:0] pre_len,
	input  wire logic [7:0] pre_seq,
	input  wire logic [6:0] fb_base,
	input  wire logic [2:0] fb_len,
	input  wire logic [7:0] fb_seq,
	input  wire logic       force_vco,
	output logic            busy
);
	import fncs_pkg::*;

	typedef enum logic [1:0] {
		H_IDLE  = 2'b00,
		H_WRITE = 2'b01
	} fncs_hst_e;

	typedef struct packed {
		fncs_hst_e  st;
		logic [7:0] addr;
		logic [7:0] wdata;
		logic       wr_stb;
		logic [7:0] v08;
		logic [7:0] v09;
		logic [7:0] v0a;
		logic [7:0] v0b;
		logic [7:0] v0c;
		logic [7:0] v0d;
	} fncs_hst_s;

	fncs_hst_s s_q;
	fncs_hst_s s_d;

	// --------------------------------------------------------------
	// Write walker
	// --------------------------------------------------------------
	always_comb begin
		s_d        = s_q;
		s_d.wr_stb = 1'b0;
		unique case (s_q.st)
			H_IDLE: begin
				if (start) begin
					s_d.v08    = {3'h0, pre_base};
					s_d.v09    = {5'h00, pre_len};
					s_d.v0a    = pre_seq;
					s_d.v0b    = {1'b0, fb_base};
					s_d.v0c    = {force_vco, 4'h0, fb_len};
					s_d.v0d    = fb_seq;
					s_d.addr   = ADDR_PRE_BASE;
					s_d.wdata  = {3'h0, pre_base};
					s_d.wr_stb = 1'b1;
					s_d.st     = H_WRITE;
				end
			end
			H_WRITE: begin
				if (s_q.addr == ADDR_SWITCH) begin
					s_d.st = H_IDLE;
				end else begin
					s_d.addr   = s_q.addr + 8'h01;
					s_d.wr_stb = 1'b1;
					unique case (s_q.addr)
						ADDR_PRE_BASE: s_d.wdata = s_q.v09;
						ADDR_PRE_LEN:  s_d.wdata = s_q.v0a;
						ADDR_PRE_SEQ:  s_d.wdata = s_q.v0b;
						ADDR_FB_BASE:  s_d.wdata = s_q.v0c;
						ADDR_FB_LEN:   s_d.wdata = s_q.v0d;
						default:       s_d.wdata = SWITCH_WORD;
					endcase
				end
			end
			default: s_d.st = H_IDLE;
		endcase
		if (bus.rst) begin
			s_d = '0;
		end
	end

	always_ff @(posedge bus.mclk) begin
		s_q <= s_d;
	end

	assign bus.wr_stb = s_q.wr_stb;
	assign bus.addr   = s_q.addr;
	assign bus.wdata  = s_q.wdata;
	assign busy       = (s_q.st != H_IDLE);

endmodule

// ---- verif/fncs_asserts.sv ----
// Checker for the synthesiser write port and its clock outputs.
// Assumes one clock, mclk, and a synchronous active-high reset, rst.
`timescale 1ns/1ps
module fncs_asserts
	import fncs_pkg::*;
(
	input wire logic       mclk,
	input wire logic       rst,
	input wire logic       wr_stb,
	input wire logic [7:0] addr,
	input wire logic       vco_tick,
	input wire logic       pll_locked,
	input wire logic       frame_sync,
	input wire logic       cp_boost,
	input wire logic       sys_tick,
	input wire logic       sys_on_pll
);
	logic [1:0] fs_q;

	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);

	// Frame syncs seen since the last settings commit, saturating at two.
	always_ff @(posedge mclk) begin
		if (rst || (wr_stb && addr == ADDR_FB_SEQ)) begin
			fs_q <= 2'h0;
		end else if (frame_sync && fs_q != 2'h2) begin
			fs_q <= fs_q + 2'h1;
		end
	end

	// --------------------------------------------------------------
	// Properties
	// --------------------------------------------------------------
	write_start_a: assert property ($rose(wr_stb) |-> addr == ADDR_PRE_BASE)
		else $error("write burst does not open at the first register");
	write_ascend_a: assert property (wr_stb && $past(wr_stb) |-> addr == $past(addr) + 8'h01)
		else $error("register writes are not ascending");
	switch_last_a: assert property (wr_stb && addr == ADDR_SWITCH |->
		$past(addr) == ADDR_FB_SEQ && $past(wr_stb) ##1 !wr_stb)
		else $error("switch request not right after the last divider write");
	boost_drop_a: assert property (pll_locked |=> !cp_boost)
		else $error("boost kept after lock");
	pll_keep_a: assert property (sys_on_pll |=> sys_on_pll)
		else $error("system clock left the loop clock");
	switch_late_a: assert property ($rose(sys_on_pll) |-> fs_q == 2'h2)
		else $error("clock switched before the second frame sync");
	sys_follow_a: assert property (sys_on_pll && $past(sys_on_pll) |-> sys_tick == $past(vco_tick))
		else $error("system tick does not follow the loop clock");
	xtal_div_a: assert property (sys_tick && !sys_on_pll |=>
		(!sys_tick || sys_on_pll)[*8] ##1 (sys_tick || sys_on_pll))
		else $error("crystal system tick not every nine cycles");

	cover property ($rose(sys_on_pll));
	cover property ($fell(cp_boost));
	cover property (wr_stb && addr == ADDR_SWITCH);
endmodule

// ---- verif/tb_top.sv ----
// Testbench joining host and synthesiser ends across the write interface.
// Assumes the loop clock model is a tick held high or toggled by the bench.
`timescale 1ns/1ps
module tb_top;
	import fncs_pkg::*;
	logic       mclk = 1'b0;
	logic       rst, start, force_vco, vco_tick, pll_locked, frame_sync, vco_tgl;
	logic       busy, ref_tick, fb_tick, cp_boost, sys_tick, sys_on_pll;
	logic [4:0] pre_base;
	logic [2:0] pre_len, fb_len;
	logic [7:0] pre_seq, fb_seq;
	logic [6:0] fb_base;
	int         failures, samples_checked, n;

	always #50 mclk = ~mclk;
	always @(posedge mclk) if (vco_tgl) vco_tick <= #1 ~vco_tick;

	fncs_if bus_if (.mclk(mclk), .rst(rst));
	fncs_host i_fncs_host (.bus(bus_if), .start(start), .pre_base(pre_base),
		.pre_len(pre_len), .pre_seq(pre_seq), .fb_base(fb_base), .fb_len(fb_len),
		.fb_seq(fb_seq), .force_vco(force_vco), .busy(busy));
	fncs_device i_fncs_device (.bus(bus_if), .vco_tick(vco_tick), .pll_locked(pll_locked),
		.frame_sync(frame_sync), .ref_tick(ref_tick), .fb_tick(fb_tick),
		.cp_boost(cp_boost), .sys_tick(sys_tick), .sys_on_pll(sys_on_pll));
	fncs_asserts i_fncs_asserts (.mclk(mclk), .rst(rst), .wr_stb(bus_if.wr_stb),
		.addr(bus_if.addr), .vco_tick(vco_tick), .pll_locked(pll_locked),
		.frame_sync(frame_sync), .cp_boost(cp_boost), .sys_tick(sys_tick),
		.sys_on_pll(sys_on_pll));

	// --------------------------------------------------------------
	// Tasks
	// --------------------------------------------------------------
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		samples_checked++;
		if (got !== exp) begin
			failures++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// Cycles until the selected tick (0 reference, 1 feedback, 2 system).
	task automatic gap(input int sel, output int c);
		c = 0;
		do begin
			@(negedge mclk);
			c++;
		end while ((sel == 0 ? ref_tick : sel == 1 ? fb_tick : sys_tick) !== 1'b1 && c < 300);
	endtask

	// Returns just after the edge that commits the set, so older ticks are past.
	task automatic prog(input logic [4:0] pb, input logic [2:0] pl, input logic [7:0] ps,
		input logic [6:0] fbb, input logic [2:0] fl, input logic [7:0] fs, input logic fv);
		int c;
		@(posedge mclk);
		#1 {pre_base, pre_len, pre_seq, fb_base, fb_len, fb_seq, force_vco} = {pb, pl, ps, fbb, fl, fs, fv};
		start = 1'b1;
		@(posedge mclk);
		#1 start = 1'b0;
		c = 0;
		do begin
			@(negedge mclk);
			c++;
		end while (!(bus_if.wr_stb === 1'b1 && bus_if.addr === ADDR_FB_SEQ) && c < 20);
		@(negedge mclk);
	endtask

	// The first tick closes position 0, so measured periods start at position 1.
	task automatic chk_div(input int sel, input logic [6:0] b, input logic [2:0] l,
		input logic [7:0] s);
		int c;
		gap(sel, c);
		for (int k = 1; k <= 2 * (l + 1); k++) begin
			gap(sel, c);
			chk(8'(c), {1'b0, b} + 8'((l != 3'h0) && s[k % (l + 1)]));
		end
	endtask

	task automatic fsync();
		@(posedge mclk);
		#1 frame_sync = 1'b1;
		@(posedge mclk);
		#1 frame_sync = 1'b0;
		repeat (12) @(negedge mclk);
	endtask

	task automatic conclude();
		$display("checked %0d mismatches %0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	// --------------------------------------------------------------
	// Sequence
	// --------------------------------------------------------------
	initial begin
		{rst, start, force_vco, vco_tick, pll_locked, frame_sync, vco_tgl} = 7'h48;
		{pre_base, pre_len, pre_seq, fb_base, fb_len, fb_seq} = '0;
		repeat (5) @(posedge mclk);
		#1 rst = 1'b0;
		chk({7'h0, cp_boost}, 8'h01);
		gap(2, n);
		gap(2, n);
		chk(8'(n), 8'h09);
		prog(5'h03, 3'h1, 8'hFE, 7'h04, 3'h4, 8'h01, 1'b0);
		chk({7'h0, busy}, 8'h01);
		fork
			chk_div(0, 7'h03, 3'h1, 8'hFE);
			chk_div(1, 7'h04, 3'h4, 8'h01);
		join
		chk({7'h0, busy}, 8'h00);
		chk({6'h00, cp_boost, sys_on_pll}, 8'h02);
		chk(bus_if.rdata, 8'h01);
		@(posedge mclk);
		#1 pll_locked = 1'b1;
		repeat (2) @(negedge mclk);
		chk({7'h0, cp_boost}, 8'h00);
		@(posedge mclk);
		#1 pll_locked = 1'b0;
		chk(bus_if.rdata, 8'h05);
		prog(5'h04, 3'h7, 8'hDA, 7'h07, 3'h0, 8'hFF, 1'b0);
		chk({7'h0, cp_boost}, 8'h01);
		fork
			chk_div(0, 7'h04, 3'h7, 8'hDA);
			chk_div(1, 7'h07, 3'h0, 8'hFF);
		join
		prog(5'h04, 3'h0, 8'hA5, 7'h7F, 3'h1, 8'h02, 1'b1);
		fork
			chk_div(0, 7'h04, 3'h0, 8'hA5);
			chk_div(1, 7'h7F, 3'h1, 8'h02);
		join
		chk({7'h0, cp_boost}, 8'h00);
		fsync();
		chk({7'h0, sys_on_pll}, 8'h00);
		fsync();
		chk({7'h0, sys_on_pll}, 8'h01);
		chk(bus_if.rdata, 8'h07);
		vco_tgl = 1'b1;
		gap(2, n);
		gap(2, n);
		chk(8'(n), 8'h02);
		conclude();
	end

	initial begin
		#400000;
		failures++;
		conclude();
	end
endmodule
